// *** hdl/ash_home_capture.sv ***
`timescale 1ns/100ps
`default_nettype none
module ash_home_capture
  import ash_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [1:0]  axis_type,
  input  wire logic        enc_index,
  input  wire logic        aux_index,
  input  wire logic        coarse_home,
  input  wire logic        home_sensor,
  input  wire logic [31:0] position,
  input  wire logic [31:0] home_value,
  input  wire logic        arm_index,
  input  wire logic        arm_edge,
  input  wire logic        find_index,
  input  wire logic        find_edge,
  input  wire logic        wait_op,
  output logic             load,
  output logic [31:0]      load_value,
  output logic             armed,
  output logic             found,
  output logic             homed,
  output logic [31:0]      captured
);

  ash_home_st_t s_ff;
  ash_home_st_t nxt_s;
  logic         home_rise;
  logic         idx_ref;
  logic         ref_event;

  // Index is qualified by coarse home; steppers with feedback use the aux index
  assign idx_ref   = (axis_type == ASH_CL_STEP ? aux_index : enc_index) & coarse_home; // see (R10)
  assign home_rise = home_sensor & ~s_ff.home_prev;
  assign ref_event = s_ff.use_edge ? home_rise : idx_ref; // see (R10)

  assign armed    = (s_ff.st == ASH_H_ARMED);
  assign found    = (s_ff.st == ASH_H_FOUND);
  assign homed    = s_ff.homed;
  assign captured = s_ff.captured;

  // Capture sequence; nothing moves unless software armed it
  always_comb begin
    nxt_s = s_ff;
    nxt_s.home_prev = home_sensor;
    load = 1'b0;
    load_value = home_value;
    unique case (s_ff.st)
      ASH_H_IDLE: begin
      end
      ASH_H_ARMED: begin
        if (ref_event) begin
          nxt_s.captured = position; // see (R11)
          if (s_ff.find) begin
            load = 1'b1; // see (R9)
            nxt_s.homed = 1'b1;
            nxt_s.st = ASH_H_IDLE;
          end else begin
            nxt_s.st = ASH_H_FOUND;
          end
        end else if (wait_op) begin
          nxt_s.find = 1'b1; // Waiting before the mark turns into a find
        end
      end
      ASH_H_FOUND: begin
        if (wait_op) begin
          // Keep motion made since the mark, relative to the home value
          load_value = home_value + (position - s_ff.captured); // see (R9)
          load = 1'b1;
          nxt_s.homed = 1'b1;
          nxt_s.st = ASH_H_IDLE;
        end
      end
      default: begin
        nxt_s.st = ASH_H_IDLE;
      end
    endcase
    // A new arm restarts the sequence; a wait in the same write still loads if the state was FOUND
    if (arm_index | arm_edge | find_index | find_edge) begin // see (R14)
      nxt_s.st = ASH_H_ARMED;
      nxt_s.use_edge = arm_edge | find_edge | (axis_type == ASH_OL_STEP); // see (R10)
      nxt_s.find = find_index | find_edge;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_no_self_home: assert property (!armed && !found |-> !load) // see (R14)
    else $error("homing load without an armed sequence");
  chk_index_capture: assert property (armed && ref_event && !s_ff.find && !arm_index && !arm_edge
    && !find_index && !find_edge |=> found && captured == $past(position)) // see (R11)
    else $error("index capture missed");

endmodule
`default_nettype wire

// *** hdl/ash_map.svh ***
`ifndef ASH_MAP_SVH
`define ASH_MAP_SVH

// Register byte offsets on the AXI4-Lite port
`define ASH_ADDR_W      8
`define ASH_OFF_CTRL    8'h00
`define ASH_OFF_LOW     8'h04
`define ASH_OFF_HIGH    8'h08
`define ASH_OFF_TARGET  8'h0C
`define ASH_OFF_POS     8'h10
`define ASH_OFF_HOMEV   8'h14
`define ASH_OFF_CMD     8'h18
`define ASH_OFF_STATUS  8'h1C
`define ASH_OFF_CAPTURE 8'h20

// Control register fields
`define ASH_CTRL_UPPER  0
`define ASH_CTRL_LOWER  1
`define ASH_CTRL_ACT    2
`define ASH_CTRL_TYPE   4

// Command register bits, write one to act
`define ASH_CMD_REEN    0
`define ASH_CMD_ARM_IDX 1
`define ASH_CMD_WAIT    2
`define ASH_CMD_FIND_IX 3
`define ASH_CMD_ARM_EDG 4
`define ASH_CMD_FIND_ED 5

// Status register bits
`define ASH_ST_ERR      0
`define ASH_ST_UPTRIP   1
`define ASH_ST_LOTRIP   2
`define ASH_ST_MOTOR    3
`define ASH_ST_ARMED    4
`define ASH_ST_FOUND    5
`define ASH_ST_HOMED    6

// Reset values
`define ASH_POS_RST     32'h0000_0000
`define ASH_LOW_RST     32'h8000_0000
`define ASH_HIGH_RST    32'h7FFF_FFFF

// Bus answers
`define ASH_RESP_OKAY   2'h0
`define ASH_RESP_SLVERR 2'h2

`endif

// *** hdl/ash_pkg.sv ***
package ash_pkg;

  typedef enum logic [1:0] {
    ASH_ACT_OFF   = 2'b00,
    ASH_ACT_HARD  = 2'b01,
    ASH_ACT_DECEL = 2'b10
  } ash_act_t;

  typedef enum logic [1:0] {
    ASH_SERVO   = 2'b00,
    ASH_CL_STEP = 2'b01,
    ASH_OL_STEP = 2'b10
  } ash_axis_t;

  typedef enum logic [1:0] {
    ASH_H_IDLE  = 2'b00,
    ASH_H_ARMED = 2'b01,
    ASH_H_FOUND = 2'b10
  } ash_hstate_t;

  typedef struct packed {
    ash_hstate_t st;
    logic        use_edge;
    logic        find;
    logic        home_prev;
    logic        homed;
    logic [31:0] captured;
  } ash_home_st_t;

  typedef struct packed {
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [5:0]  ctrl;
    logic [31:0] low_bound;
    logic [31:0] high_bound;
    logic [31:0] target;
    logic [31:0] home_value;
    logic [31:0] position;
    logic        motor_on;
    logic        err;
    logic        up_trip;
    logic        lo_trip;
    logic        hard_stop;
    logic        decel_stop;
    logic        move_start;
  } ash_main_st_t;

endpackage

// *** hdl/ash_soft_limit_home.sv ***
// How it works
// (R1) A commanded target outside enabled travel bounds flags an error and stops.
// (R2) Upper and lower bounds enable separately or together; disabled bounds never trip.
// (R3) Trip response is selectable: motor off, hard stop, or decelerate to stop.
// (R4) A trip sets axis error plus direction flag, held until the axis is re-enabled.
// (R5) After re-enabling, host moves the axis back inside the allowed range.
// (R6) Reset clears the position counter to zero.
// (R7) Position reads as offset from the last initialisation or redefinition.
// (R8) A set-position write overwrites the current position at any time.
// (R9) A detected homing reference loads the position with the user home value.
// (R10) Index plus coarse home for servo axes; home edge alone for open-loop steppers.
// (R11) Index homing captures the position at the encoder index mark.
// (R12) Host issues single-command find variants only from background tasks.
// (R13) Homing runs in the background so several axes may home at once.
// (R14) No built-in homing; only software-armed sequences ever load the position.
// (R15) Bounds compare signed; below low trips negative, above high trips positive.
`timescale 1ns/100ps
`default_nettype none
`include "ash_map.svh"
module ash_soft_limit_home
  import ash_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        enc_step,
  input  wire logic        enc_dir,
  input  wire logic        enc_index,
  input  wire logic        aux_index,
  input  wire logic        coarse_home,
  input  wire logic        home_sensor,
  output logic             motor_enable,
  output logic             hard_stop,
  output logic             decel_stop,
  output logic             move_start,
  output logic [31:0]      move_target
);

  ash_main_st_t s_ff;
  ash_main_st_t nxt_s;

  logic        aw_go;
  logic        w_go;
  logic        ar_go;
  logic        wr_go;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [31:0] wv;
  logic        upper_bound_enable;
  logic        lower_bound_enable;
  logic        hi_trip;
  logic        lo_trip;
  logic        trip;
  logic        tgt_wr;
  logic        cmd_wr;
  logic        axis_reenable_cmd;
  logic        home_load;
  logic [31:0] home_load_value;
  logic        home_armed;
  logic        home_found;
  logic        home_homed;
  logic [31:0] home_captured;
  ash_act_t    trip_action;

  // True for every offset the register file answers
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `ASH_OFF_CTRL, `ASH_OFF_LOW, `ASH_OFF_HIGH, `ASH_OFF_TARGET,
      `ASH_OFF_POS, `ASH_OFF_HOMEV, `ASH_OFF_CMD, `ASH_OFF_STATUS,
      `ASH_OFF_CAPTURE: is_mapped = 1'b1;
      default:          is_mapped = 1'b0;
    endcase
  endfunction

  // Read view of a register; also the base for byte-lane merges
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    case (a)
      `ASH_OFF_CTRL:    reg_read = {26'h0, s_ff.ctrl};
      `ASH_OFF_LOW:     reg_read = s_ff.low_bound;
      `ASH_OFF_HIGH:    reg_read = s_ff.high_bound;
      `ASH_OFF_TARGET:  reg_read = s_ff.target;
      `ASH_OFF_POS:     reg_read = s_ff.position; // see (R7)
      `ASH_OFF_HOMEV:   reg_read = s_ff.home_value;
      `ASH_OFF_STATUS:  reg_read = {25'h0, home_homed, home_found, home_armed,
                                    s_ff.motor_on, s_ff.lo_trip, s_ff.up_trip, s_ff.err};
      `ASH_OFF_CAPTURE: reg_read = home_captured;
      default:          reg_read = 32'h0000_0000;
    endcase
  endfunction

  // Byte-lane merge honouring wstrb
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // AXI handshakes: one write and one read in flight, address and data in any order
  assign awready = ~s_ff.aw_hold & ~s_ff.bvalid;
  assign wready  = ~s_ff.w_hold & ~s_ff.bvalid;
  assign arready = ~s_ff.rvalid;
  assign aw_go   = awvalid & awready;
  assign w_go    = wvalid & wready;
  assign ar_go   = arvalid & arready;
  assign wr_go   = (s_ff.aw_hold | aw_go) & (s_ff.w_hold | w_go) & ~s_ff.bvalid;
  assign wr_addr = s_ff.aw_hold ? s_ff.aw_addr : awaddr;
  assign wr_data = s_ff.w_hold ? s_ff.w_data : wdata;
  assign wr_strb = s_ff.w_hold ? s_ff.w_strb : wstrb;

  // Process form, so that register contents read inside the functions also wake it
  always_comb begin
    wv = merge(reg_read(wr_addr), wr_data, wr_strb);
  end

  // Bound enables; both bits set is the both-bounds setting
  assign upper_bound_enable = s_ff.ctrl[`ASH_CTRL_UPPER];
  assign lower_bound_enable = s_ff.ctrl[`ASH_CTRL_LOWER];
  assign trip_action        = ash_act_t'(s_ff.ctrl[`ASH_CTRL_ACT +: 2]);

  // Signed compare of the new target against enabled bounds only
  assign hi_trip = upper_bound_enable & ($signed(wv) > $signed(s_ff.high_bound)); // see (R15) (R2)
  assign lo_trip = lower_bound_enable & ($signed(wv) < $signed(s_ff.low_bound));  // see (R15) (R2)
  assign tgt_wr  = wr_go & (wr_addr == `ASH_OFF_TARGET);
  assign trip    = tgt_wr & s_ff.motor_on & (hi_trip | lo_trip); // see (R1)
  assign cmd_wr  = wr_go & (wr_addr == `ASH_OFF_CMD);
  assign axis_reenable_cmd = cmd_wr & wv[`ASH_CMD_REEN];

  // Homing capture; runs alongside bus traffic and motion, never blocking either
  ash_home_capture u_home (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .axis_type   (s_ff.ctrl[`ASH_CTRL_TYPE +: 2]),
    .enc_index   (enc_index),
    .aux_index   (aux_index),
    .coarse_home (coarse_home),
    .home_sensor (home_sensor),
    .position    (s_ff.position),
    .home_value  (s_ff.home_value),
    .arm_index   (cmd_wr & wv[`ASH_CMD_ARM_IDX]),
    .arm_edge    (cmd_wr & wv[`ASH_CMD_ARM_EDG]),
    .find_index  (cmd_wr & wv[`ASH_CMD_FIND_IX]), // see (R13)
    .find_edge   (cmd_wr & wv[`ASH_CMD_FIND_ED]), // see (R13)
    .wait_op     (cmd_wr & wv[`ASH_CMD_WAIT]),
    .load        (home_load),
    .load_value  (home_load_value),
    .armed       (home_armed),
    .found       (home_found),
    .homed       (home_homed),
    .captured    (home_captured)
  );

  // Next-state logic for bus, limits and position
  always_comb begin
    nxt_s = s_ff;
    nxt_s.hard_stop  = 1'b0;
    nxt_s.decel_stop = 1'b0;
    nxt_s.move_start = 1'b0;
    if (aw_go) begin
      nxt_s.aw_hold = 1'b1;
      nxt_s.aw_addr = awaddr;
    end
    if (w_go) begin
      nxt_s.w_hold = 1'b1;
      nxt_s.w_data = wdata;
      nxt_s.w_strb = wstrb;
    end
    if (s_ff.bvalid & bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.rvalid & rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (ar_go) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata  = reg_read(araddr);
      nxt_s.rresp  = is_mapped(araddr) ? `ASH_RESP_OKAY : `ASH_RESP_SLVERR;
    end
    // Encoder steps; dir high counts down
    if (enc_step) begin
      nxt_s.position = enc_dir ? s_ff.position - 32'h0000_0001
                               : s_ff.position + 32'h0000_0001;
    end
    // Homing load outranks counting; a software write outranks both
    if (home_load) begin
      nxt_s.position = home_load_value; // see (R9)
    end
    if (wr_go) begin
      nxt_s.aw_hold = 1'b0;
      nxt_s.w_hold  = 1'b0;
      nxt_s.bvalid  = 1'b1;
      nxt_s.bresp   = is_mapped(wr_addr) ? `ASH_RESP_OKAY : `ASH_RESP_SLVERR;
      case (wr_addr)
        `ASH_OFF_CTRL:  nxt_s.ctrl = wv[5:0];
        `ASH_OFF_LOW:   nxt_s.low_bound = wv;
        `ASH_OFF_HIGH:  nxt_s.high_bound = wv;
        `ASH_OFF_HOMEV: nxt_s.home_value = wv;
        `ASH_OFF_POS:   nxt_s.position = wv; // see (R8)
        `ASH_OFF_TARGET: begin
          // Moves are refused while the motor is off, so an axis tripped with the motor-off response stays put
          if (s_ff.motor_on & ~trip) begin
            nxt_s.target     = wv;
            nxt_s.move_start = 1'b1;
          end
        end
        `ASH_OFF_CMD: begin
          if (wv[`ASH_CMD_REEN]) begin
            nxt_s.motor_on = 1'b1; // see (R4)
            nxt_s.err      = 1'b0;
            nxt_s.up_trip  = 1'b0;
            nxt_s.lo_trip  = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Trip: flags latch, the chosen stop response fires once
    if (trip) begin
      nxt_s.err     = 1'b1; // see (R4) (R1)
      nxt_s.up_trip = s_ff.up_trip | hi_trip; // see (R15)
      nxt_s.lo_trip = s_ff.lo_trip | lo_trip; // see (R15)
      case (trip_action)
        ASH_ACT_HARD:  nxt_s.hard_stop = 1'b1; // see (R3)
        ASH_ACT_DECEL: nxt_s.decel_stop = 1'b1; // see (R3)
        default:       nxt_s.motor_on = 1'b0; // see (R3)
      endcase
    end
  end

  // State register; position starts at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff            <= '0;
      s_ff.position   <= `ASH_POS_RST; // see (R6)
      s_ff.low_bound  <= `ASH_LOW_RST;
      s_ff.high_bound <= `ASH_HIGH_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from flops
  assign bvalid       = s_ff.bvalid;
  assign bresp        = s_ff.bresp;
  assign rvalid       = s_ff.rvalid;
  assign rdata        = s_ff.rdata;
  assign rresp        = s_ff.rresp;
  assign motor_enable = s_ff.motor_on;
  assign hard_stop    = s_ff.hard_stop;
  assign decel_stop   = s_ff.decel_stop;
  assign move_start   = s_ff.move_start;
  assign move_target  = s_ff.target;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_upper_trip_flag: assert property (tgt_wr && s_ff.motor_on && upper_bound_enable // see (R1)
    && $signed(wv) > $signed(s_ff.high_bound) |=> s_ff.err && s_ff.up_trip && !move_start)
    else $error("upper bound trip not flagged");

  chk_lower_trip_flag: assert property (tgt_wr && s_ff.motor_on && lower_bound_enable // see (R15)
    && $signed(wv) < $signed(s_ff.low_bound) |=> s_ff.err && s_ff.lo_trip)
    else $error("lower bound trip not flagged");

  chk_disabled_bounds: assert property (tgt_wr && s_ff.motor_on && !upper_bound_enable // see (R2)
    && !lower_bound_enable |=> move_start && !$rose(s_ff.err))
    else $error("disabled bounds produced a trip");

  chk_off_action: assert property (trip && trip_action == ASH_ACT_OFF // see (R3)
    |=> !motor_enable && !hard_stop && !decel_stop)
    else $error("motor-off response wrong");

  chk_decel_action: assert property (trip && trip_action == ASH_ACT_DECEL // see (R3)
    |=> decel_stop && motor_enable ##1 !decel_stop)
    else $error("decel response wrong");

  chk_flags_held: assert property (s_ff.err && !axis_reenable_cmd |=> s_ff.err) // see (R4)
    else $error("error flag dropped without re-enable");

  chk_reenable_clear: assert property (axis_reenable_cmd && !trip // see (R4)
    |=> !s_ff.err && !s_ff.up_trip && !s_ff.lo_trip && motor_enable)
    else $error("re-enable did not clear flags");

  chk_reset_zero: assert property (disable iff (1'b0) !aresetn |=> s_ff.position == 32'h0000_0000) // see (R6)
    else $error("position not zero after reset");

  chk_set_position: assert property (wr_go && wr_addr == `ASH_OFF_POS // see (R8)
    |=> s_ff.position == $past(wv))
    else $error("set position not applied");

  chk_home_load: assert property (home_load && !(wr_go && wr_addr == `ASH_OFF_POS) // see (R9)
    |=> s_ff.position == $past(home_load_value))
    else $error("homing load not applied");

  chk_write_answer: assert property (wr_go |=> bvalid && !awready && !wready)
    else $error("write answer missing");

  chk_read_answer: assert property (ar_go |=> rvalid && !arready)
    else $error("read answer missing");

  chk_hard_action: assert property (trip && trip_action == ASH_ACT_HARD // see (R3)
    |=> hard_stop && motor_enable ##1 !hard_stop)
    else $error("hard-stop response wrong");

  chk_target_load: assert property (tgt_wr && s_ff.motor_on && !trip // see (R1)
    |=> move_start && move_target == $past(wv))
    else $error("accepted target not loaded");

  chk_refuse_off: assert property (tgt_wr && !s_ff.motor_on |=> !move_start) // see (R1)
    else $error("target accepted with motor off");

  cov_trip_decel: cover property (trip && trip_action == ASH_ACT_DECEL);
  cov_trip_hard: cover property (trip && trip_action == ASH_ACT_HARD);
  cov_home_load: cover property (home_load);
  cov_trip_reenable: cover property (s_ff.err ##[1:50] axis_reenable_cmd);

endmodule
`default_nettype wire

// *** verification/ash_drive_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ash_drive_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       motor_enable,
  input  wire logic       hard_stop,
  input  wire logic       decel_stop,
  input  wire logic       step_go,
  input  wire logic [7:0] step_n,
  input  wire logic       step_dir,
  input  wire logic       ev_go,
  input  wire logic [1:0] ev_src,
  input  wire logic       ev_coarse,
  output logic            enc_step = 1'b0,
  output logic            enc_dir = 1'b0,
  output logic            enc_index,
  output logic            aux_index,
  output logic            coarse_home,
  output logic            home_sensor,
  output logic            busy
);
  logic [7:0] left_ff = 8'h00;
  logic [2:0] ev_ff = 3'h0;
  logic       stop;

  // A real drive quits at once on any stop request, so pending counts die
  assign stop = hard_stop || decel_stop || !motor_enable;

  // One encoder count per cycle while the axis is powered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_ff <= 8'h00;
      ev_ff <= 3'h0;
      enc_step <= 1'b0;
    end else begin
      enc_step <= (left_ff != 8'h00) && !stop;
      left_ff <= stop ? 8'h00 : step_go ? step_n : (left_ff != 8'h00) ? left_ff - 8'h01 : 8'h00;
      if (step_go) enc_dir <= step_dir;
      ev_ff <= ev_go ? 3'h4 : (ev_ff != 3'h0) ? ev_ff - 3'h1 : 3'h0;
    end
  end

  // Index mark sits mid-window of the coarse sensor; home edge rises there too
  assign coarse_home = (ev_ff != 3'h0) && ev_coarse;
  assign enc_index   = (ev_ff == 3'h2) && (ev_src == 2'h0);
  assign aux_index   = (ev_ff == 3'h2) && (ev_src == 2'h1);
  assign home_sensor = (ev_ff != 3'h0) && (ev_ff <= 3'h2) && (ev_src == 2'h2);
  assign busy        = (left_ff != 8'h00) || (ev_ff != 3'h0) || enc_step;
endmodule
`default_nettype wire

// *** verification/test_ash_soft_limit_home.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ash_map.svh"
module test_ash_soft_limit_home
  import ash_pkg::*;
;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = '0, araddr = '0, sn = '0;
  logic [31:0] wdata = '0, rd, rdata, move_target;
  logic [3:0]  wstrb = '0;
  logic [1:0]  bresp, rresp, rs, esrc = '0;
  logic        awready, wready, bvalid, arready, rvalid, motor_enable, hard_stop, decel_stop, move_start;
  logic        enc_step, enc_dir, enc_index, aux_index, coarse_home, home_sensor, busy;
  logic        sgo = 0, ego = 0, sdir = 0, eco = 0;
  int          failures = 0, checked = 0, cyc = 0, seed = 80;
  int          hs = 0, ds = 0, ms = 0, eh = 0, ed = 0, em = 0, ep = 0, n, up, lo, hv;
  int          ten[7] = '{1, 1, 2, 2, 3, 3, 3};
  int          tt[7] = '{-5, 491, 600, 9, 490, 10, 491};
  int          ht[4] = '{0, 1, 2, 2}, hc[4] = '{8, 2, 32, 16}, hw[4] = '{0, 1, 0, 1};

  ash_soft_limit_home i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .enc_step, .enc_dir, .enc_index, .aux_index, .coarse_home, .home_sensor, .motor_enable,
    .hard_stop, .decel_stop, .move_start, .move_target);

  ash_drive_model i_drv (.aclk, .aresetn, .motor_enable, .hard_stop, .decel_stop, .step_go(sgo),
    .step_n(sn), .step_dir(sdir), .ev_go(ego), .ev_src(esrc), .ev_coarse(eco), .enc_step, .enc_dir,
    .enc_index, .aux_index, .coarse_home, .home_sensor, .busy);

  // Free-running bus clock
  initial begin
    forever #50 aclk = ~aclk;
  end

  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Each valid holds until the rising edge that samples its ready; bready and rready stay high
  task axw(input logic [7:0] a, input logic [31:0] d);
    bit dn;
    dn = 0;
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1;
    while (!dn) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid === 1'b1) begin
        rs = bresp;
        dn = 1;
      end
    end
  endtask

  task axr(input logic [7:0] a, output logic [31:0] d);
    bit dn;
    dn = 0;
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    while (!dn) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid === 1'b1) begin
        d = rdata;
        rs = rresp;
        dn = 1;
      end
    end
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    axr(a, rd);
    chk(nm, rd, e);
  endtask

  // Either a burst of counts or one reference event, then wait until the far side is quiet
  task drv(input logic e, input logic [1:0] s, input logic c, input logic [7:0] cnt, input logic d);
    sgo <= !e;
    ego <= e;
    esrc <= s;
    eco <= c;
    sn <= cnt;
    sdir <= d;
    @(posedge aclk);
    sgo <= 0;
    ego <= 0;
    do @(negedge aclk); while (busy);
    @(posedge aclk);
  endtask

  task step_rand;
    int d;
    n = ($random(seed) & 15) + 1;
    d = $random(seed) & 1;
    drv(0, 2'h0, 0, n[7:0], d[0]);
    ep = (d != 0) ? ep - n : ep + n;
  endtask

  // Pulse counters and the hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (hard_stop) hs <= hs + 1;
    if (decel_stop) ds <= ds + 1;
    if (move_start) ms <= ms + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test;
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc(`ASH_OFF_POS, `ASH_POS_RST, "pos");
    rc(`ASH_OFF_LOW, `ASH_LOW_RST, "low");
    rc(`ASH_OFF_HIGH, `ASH_HIGH_RST, "high");
    rc(`ASH_OFF_STATUS, 32'h0, "status");
    rc(8'h24, 32'h0, "unmapped");
    chk("rresp", {30'h0, rs}, {30'h0, `ASH_RESP_SLVERR});
    axw(8'h24, 32'h1);
    chk("bresp", {30'h0, rs}, {30'h0, `ASH_RESP_SLVERR});
    axw(`ASH_OFF_LOW, 32'hA);
    axw(`ASH_OFF_HIGH, 32'h1EA);
    axw(`ASH_OFF_TARGET, 32'h64);
    // Every action against upper, lower and both bounds enabled, boundaries included
    for (int a = 0; a < 4; a++) begin
      for (int j = 0; j < 7; j++) begin
        axw(`ASH_OFF_CMD, 32'h1);
        axw(`ASH_OFF_CTRL, 32'(a * 4 + ten[j]));
        axw(`ASH_OFF_TARGET, 32'(tt[j]));
        up = ((ten[j] & 1) != 0 && tt[j] > 490) ? 1 : 0;
        lo = ((ten[j] & 2) != 0 && tt[j] < 10) ? 1 : 0;
        if (up + lo == 0) begin
          em++;
          chk("target", move_target, 32'(tt[j]));
        end else if (a == 1) eh++;
        else if (a == 2) ed++;
        n = (up + lo != 0 && (a == 0 || a == 3)) ? 0 : 8;
        rc(`ASH_OFF_STATUS, 32'(n + up + lo + 2 * up + 4 * lo), "status");
        chk("motor", {31'h0, motor_enable}, 32'(n / 8));
        chk("pulses", 32'(hs * 65536 + ds * 256 + ms), 32'(eh * 65536 + ed * 256 + em));
      end
    end
    axw(`ASH_OFF_CMD, 32'h1);
    axw(`ASH_OFF_CTRL, 32'h0);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        axw(`ASH_OFF_POS, 32'h3E8);
        ep = 1000;
        rc(`ASH_OFF_POS, 32'h3E8, "setpos");
      end
      step_rand;
      rc(`ASH_OFF_POS, 32'(ep), "pos");
    end
    drv(1, 2'h0, 1, 8'h00, 0);
    rc(`ASH_OFF_POS, 32'(ep), "idle");
    axw(`ASH_OFF_CMD, 32'h8);
    drv(1, 2'h0, 0, 8'h00, 0);
    rc(`ASH_OFF_POS, 32'(ep), "unqual");
    // Find on index, arm-then-wait on aux index, both find and arm-then-wait on home edge
    for (int j = 0; j < 4; j++) begin
      hv = 256 + 16 * j;
      axw(`ASH_OFF_HOMEV, 32'(hv));
      axw(`ASH_OFF_CTRL, 32'(ht[j] * 16));
      axw(`ASH_OFF_CMD, 32'(hc[j]));
      drv(1, 2'(ht[j]), 1, 8'h00, 0);
      ep = hv;
      if (hw[j] != 0) begin
        axr(`ASH_OFF_STATUS, rd);
        chk("found", rd & 32'h20, 32'h20);
        rc(`ASH_OFF_CAPTURE, 32'(hv - 16), "capture");
        step_rand;
        axw(`ASH_OFF_CMD, 32'h4);
      end
      rc(`ASH_OFF_POS, 32'(ep), "home");
      axr(`ASH_OFF_STATUS, rd);
      chk("homed", rd & 32'h40, 32'h40);
    end
    end_of_test;
  end
endmodule
`default_nettype wire
